// ---- rtl/gpc_defs.svh ----
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH
// ==========================================================
// Register byte offsets
`define GPC_DATA_TOP   12'h3FC
`define GPC_DIR        12'h400
`define GPC_HWCTL      12'h404
`define GPC_PADEN      12'h408
`define GPC_FSEL       12'h40C
`define GPC_ITYPE      12'h410
`define GPC_IMASK      12'h414
`define GPC_RAWST      12'h418
`define GPC_MSKST      12'h41C
`define GPC_ICLR       12'h420
`define GPC_ADCEN      12'h424
`define GPC_DMAEN      12'h428
`define GPC_LOCK       12'h42C
`define GPC_COMMIT     12'h430
`define GPC_MODE_BASE  12'h440
// ==========================================================
// Field positions
`define GPC_DMA_SRC    8
// ==========================================================
// Reset values and keys
`define GPC_PROT_RST   8'h0F
`define GPC_UNLOCK_KEY 32'h4C0C_4B1E
`endif

// ---- rtl/gpc_pkg.sv ----
// ==========================================================
// Types shared by the port block
package gpc_pkg;
  typedef logic [7:0] gpc_pin_t;
  typedef enum logic [1:0] {
    GPC_DIR_IN  = 2'h0,
    GPC_DIR_OUT = 2'h1,
    dir_hardware_control = 2'h2
  } gpc_dir_mode_e;
  typedef enum logic [2:0] {
    GPC_INT_FALL = 3'h0,
    GPC_INT_RISE = 3'h1,
    GPC_INT_BOTH = 3'h2,
    GPC_INT_LOW  = 3'h3,
    GPC_INT_HIGH = 3'h4
  } gpc_int_type_e;
endpackage

// ---- rtl/gpc_top.sv ----
// What this block does
// - Multi-pin operations act on mask-selected pins only
// - Pins are software input, output, or hardware
// - Single pin mode reads back as code
// - Pad enable gates pin signals both ways
// - Protected pins change direction, mode, pad and selector only after unlock, commit
// - Per-pin enable for converter trigger
// - Clearing converter enable stops that pin only
// - Per-pin enable for transfer engine request
// - Clearing transfer enable stops its requests
// - Trigger pins still raise pin interrupts
// - Only enabled sources reach interrupt line
// - Nine sources: eight pins plus transfer
// - Clear resets only the written mask
// - Function selector routes peripheral signal to pin
// - All pins are inputs after reset
// - Data address bits mask read and write
// - Edge or level interrupt detection per pin
// - Raw and masked status both readable
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "gpc_defs.svh"
module gpc_top #(
  parameter logic [7:0] PROT_PINS = `GPC_PROT_RST
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pads
  input  wire gpc_pkg::gpc_pin_t pin_in,
  output gpc_pkg::gpc_pin_t      pin_out,
  output gpc_pkg::gpc_pin_t      pin_oe,
  // Peripheral functions
  input  wire logic [3:0]        alt_out,
  input  wire logic [3:0]        alt_oe,
  output logic      [3:0]        alt_in,
  // Triggers and interrupt
  output logic                   adc_trig,
  output gpc_pkg::gpc_pin_t      dma_req,
  input  wire logic              dma_done,
  output logic                   irq
);
  import gpc_pkg::*;

  // ==========================================================
  // Bus decode
  logic        wr;
  logic        setup;
  logic [8:0]  clr;
  gpc_pin_t    dir_r, hw_r, paden_r, data_r, commit_r, adcen_r, dmaen_r;
  gpc_pin_t    in_s, prev_r, ev, wmask;
  logic [1:0]  fsel_r [8];
  logic [2:0]  itype_r [8];
  logic [8:0]  im_r, ris_r, ev_all;
  logic        lock_r;
  logic [15:0] fsel_rd;
  logic [31:0] itype_rd;
  logic [31:0] rd_nxt;
  logic        err_nxt;

  // Writes land at the access edge; pready never drops after reset
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & pready;
  // Committed pins only accept direction, mode, pad and selector writes
  assign wmask = commit_r;
  assign clr   = (wr && paddr == `GPC_ICLR) ? pwdata[8:0] : 9'h0;
  assign in_s  = pin_in & paden_r;

  // ==========================================================
  // Handshake: zero wait, answer prepared in setup
  // Read data is taken at the setup edge, so a register that
  // changes on that same edge still shows its old value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= rd_nxt;
        pslverr <= err_nxt;
      end
    end
  end

  // ==========================================================
  // Lock and commit
  // Any value but the key relocks, so stray writes close it again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r   <= 1'b1;
      commit_r <= ~PROT_PINS;
    end else begin
      if (wr && paddr == `GPC_LOCK) lock_r <= (pwdata != `GPC_UNLOCK_KEY);
      if (wr && paddr == `GPC_COMMIT && !lock_r) commit_r <= pwdata[7:0] | ~PROT_PINS;
    end
  end

  // Direction, control mode, pad and data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r   <= 8'h00;
      hw_r    <= 8'h00;
      paden_r <= 8'h00;
      data_r  <= 8'h00;
    end else if (wr) begin
      if (paddr == `GPC_DIR) dir_r <= (dir_r & ~wmask) | (pwdata[7:0] & wmask);
      if (paddr == `GPC_HWCTL) hw_r <= (hw_r & ~wmask) | (pwdata[7:0] & wmask);
      if (paddr == `GPC_PADEN) paden_r <= (paden_r & ~wmask) | (pwdata[7:0] & wmask);
      // Address bits 9:2 select the pins written
      if (paddr <= `GPC_DATA_TOP) begin
        data_r <= (data_r & ~paddr[9:2]) | (pwdata[7:0] & paddr[9:2]);
      end
    end
  end

  // Interrupt mask and trigger enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      im_r    <= 9'h0;
      adcen_r <= 8'h00;
      dmaen_r <= 8'h00;
    end else if (wr) begin
      if (paddr == `GPC_IMASK) im_r <= pwdata[8:0];
      if (paddr == `GPC_ADCEN) adcen_r <= pwdata[7:0];
      if (paddr == `GPC_DMAEN) dmaen_r <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Per-pin function select, detection and pad drive
  for (genvar n = 0; n < 8; n++) begin : g_pin
    // Selector commit guarded; detection type always writable
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fsel_r[n]  <= 2'h0;
        itype_r[n] <= 3'h0;
      end else if (wr) begin
        if (paddr == `GPC_FSEL && wmask[n]) fsel_r[n] <= pwdata[2*n+:2];
        if (paddr == `GPC_ITYPE) itype_r[n] <= pwdata[4*n+:3];
      end
    end
    // Detector
    // Level types re-set status each cycle the level holds
    always_comb begin
      case (itype_r[n])
        GPC_INT_FALL: ev[n] = prev_r[n] & ~in_s[n];
        GPC_INT_RISE: ev[n] = ~prev_r[n] & in_s[n];
        GPC_INT_BOTH: ev[n] = prev_r[n] ^ in_s[n];
        GPC_INT_LOW:  ev[n] = ~in_s[n];
        GPC_INT_HIGH: ev[n] = in_s[n];
        default:      ev[n] = 1'b0;
      endcase
    end
    // Pad output, from data or the chosen peripheral
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_out[n] <= 1'b0;
        pin_oe[n]  <= 1'b0;
      end else begin
        pin_out[n] <= hw_r[n] ? alt_out[fsel_r[n]] : data_r[n];
        pin_oe[n]  <= paden_r[n] & (hw_r[n] ? alt_oe[fsel_r[n]] : dir_r[n]);
      end
    end
    assign fsel_rd[2*n+:2]  = fsel_r[n];
    assign itype_rd[4*n+:4] = {1'b0, itype_r[n]};
  end

  // Peripheral inputs gathered from routed pins
  // prev_r resets low like the gated pad, so no edge follows reset
  // Several pins routed to one signal are ORed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_in <= 4'h0;
      prev_r <= 8'h00;
    end else begin
      prev_r <= in_s;
      for (int k = 0; k < 4; k++) begin
        alt_in[k] <= 1'b0;
        for (int n = 0; n < 8; n++) begin
          if (hw_r[n] && fsel_r[n] == k[1:0] && in_s[n]) alt_in[k] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Status, interrupt and trigger outputs
  assign ev_all = {dma_done, ev};
  // Set beats clear, so an event on the clear edge is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_r    <= 9'h0;
      irq      <= 1'b0;
      adc_trig <= 1'b0;
      dma_req  <= 8'h00;
    end else begin
      ris_r    <= (ris_r & ~clr) | ev_all;
      irq      <= |(ris_r & im_r);
      adc_trig <= |(ev & adcen_r);
      dma_req  <= ev & dmaen_r;
    end
  end

  // ==========================================================
  // Read mux
  // Output pins read the data register, others the gated pad
  always_comb begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    if (paddr <= `GPC_DATA_TOP) begin
      rd_nxt[7:0] = ((data_r & dir_r & ~hw_r) | (in_s & ~(dir_r & ~hw_r))) & paddr[9:2];
    end else if (paddr[11:5] == `GPC_MODE_BASE >> 5) begin
      // One pin's mode code
      if (hw_r[paddr[4:2]]) rd_nxt[1:0] = dir_hardware_control;
      else if (dir_r[paddr[4:2]]) rd_nxt[1:0] = GPC_DIR_OUT;
      else rd_nxt[1:0] = GPC_DIR_IN;
    end else begin
      case (paddr)
        `GPC_DIR:    rd_nxt[7:0]  = dir_r;
        `GPC_HWCTL:  rd_nxt[7:0]  = hw_r;
        `GPC_PADEN:  rd_nxt[7:0]  = paden_r;
        `GPC_FSEL:   rd_nxt[15:0] = fsel_rd;
        `GPC_ITYPE:  rd_nxt       = itype_rd;
        `GPC_IMASK:  rd_nxt[8:0]  = im_r;
        `GPC_RAWST:  rd_nxt[8:0]  = ris_r;
        `GPC_MSKST:  rd_nxt[8:0]  = ris_r & im_r;
        `GPC_ICLR:   rd_nxt       = 32'h0;
        `GPC_ADCEN:  rd_nxt[7:0]  = adcen_r;
        `GPC_DMAEN:  rd_nxt[7:0]  = dmaen_r;
        `GPC_LOCK:   rd_nxt[0]    = lock_r;
        `GPC_COMMIT: rd_nxt[7:0]  = commit_r;
        default:     err_nxt      = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Interrupt status and line
  a_irq_gated: assert property ((im_r == 9'h0) [*2] |-> !irq)
    else $error("irq with all sources disabled");
  a_irq_follow: assert property (irq == $past(|(ris_r & im_r)))
    else $error("irq not following masked status");
  a_clear_masked: assert property (clr != 9'h0 |=>
    ($past(ris_r) & ~$past(clr) & ~ris_r) == 9'h0)
    else $error("clear touched unselected source");
  a_clear_hits: assert property (clr != 9'h0 |=>
    (ris_r & $past(clr) & ~$past(ev_all)) == 9'h0)
    else $error("selected source not cleared");
  a_set_wins: assert property (ev_all != 9'h0 |=> ($past(ev_all) & ~ris_r) == 9'h0)
    else $error("event lost against clear");
  a_level_keep: assert property (itype_r[0] == GPC_INT_HIGH && in_s[0] |=> ris_r[0])
    else $error("high level did not hold status");
  a_irq_trig: assert property (ev[0] && adcen_r[0] && im_r[0] ##1 im_r[0] |-> ##1 irq)
    else $error("trigger suppressed interrupt");

  // Converter and transfer triggers
  a_adc_gate: assert property (adc_trig |-> $past((ev & adcen_r) != 8'h00))
    else $error("trigger from disabled pin");
  a_adc_fire: assert property ((ev & adcen_r) != 8'h00 |=> adc_trig)
    else $error("enabled pin event gave no trigger");
  a_dma_gate: assert property ((dma_req & ~$past(dmaen_r)) == 8'h00)
    else $error("request from disabled pin");
  a_dma_fire: assert property (dma_req == $past(ev & dmaen_r))
    else $error("request not following enabled events");

  // Configuration, lock and pads
  a_pad_gate: assert property ((pin_oe & ~$past(paden_r)) == 8'h00)
    else $error("drive without pad enable");
  a_in_gate: assert property ((prev_r & ~$past(paden_r)) == 8'h00)
    else $error("input seen without pad enable");
  a_mode_drive: assert property ((pin_oe & ~$past(hw_r | dir_r)) == 8'h00)
    else $error("input pin driven");
  a_hw_pin0: assert property (hw_r[0] && paden_r[0] |=>
    pin_oe[0] == $past(alt_oe[fsel_r[0]]))
    else $error("hardware pin not driven by peripheral");
  a_data_mask: assert property (wr && paddr <= `GPC_DATA_TOP |=>
    ((data_r ^ $past(data_r)) & ~$past(paddr[9:2])) == 8'h00)
    else $error("unselected data bit changed");
  a_lock_hold: assert property (wr && paddr == `GPC_DIR |=>
    ((dir_r ^ $past(dir_r)) & ~$past(commit_r)) == 8'h00)
    else $error("uncommitted pin changed");
  a_commit_lock: assert property (wr && paddr == `GPC_COMMIT && lock_r |=>
    $stable(commit_r))
    else $error("commit changed while locked");
  a_lock_key: assert property (wr && paddr == `GPC_LOCK && pwdata == `GPC_UNLOCK_KEY |=>
    !lock_r)
    else $error("key did not unlock");

  // Main scenarios reached
  c_irq: cover property ($rose(irq));
  c_adc: cover property (adc_trig);
  c_dma: cover property (dma_req != 8'h00);
  c_unlock: cover property ($fell(lock_r));
  c_set_wins: cover property ((clr & ev_all) != 9'h0);
endmodule

// ---- tb/gpc_pad_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Pads and peripheral functions outside the port
module gpc_pad_model (
  // Port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in,
  output logic      [3:0] alt_out,
  output logic      [3:0] alt_oe,
  // Bench control
  input  wire logic [7:0] ext_lvl,
  input  wire logic [3:0] per_out,
  input  wire logic [3:0] per_oe
);
  // Driven pads show the port value, others the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  // Peripheral signals offered to the selector
  assign alt_out = per_out;
  assign alt_oe  = per_oe;
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`include "gpc_defs.svh"
// ==========================================================
// Self-checking bench for the port
module tb;
  import gpc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dma_done = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, mk, dm, ad, c, seed = 32'hC4213A54;
  logic        pready, pslverr, er, adc_trig, irq, aacc;
  gpc_pin_t    pin_in, pin_out, pin_oe, dma_req, dacc, ext = 0;
  logic [3:0]  alt_out, alt_oe, alt_in, per_out = 0, per_oe = 0;
  logic [7:0]  a, b, re, lv;
  logic [8:0]  rs;
  int          err_count = 0, total_checks = 0, cyc = 0;
  gpc_top u_gpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .adc_trig(adc_trig),
    .dma_req(dma_req), .dma_done(dma_done), .irq(irq));
  gpc_pad_model u_gpc_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .alt_out(alt_out), .alt_oe(alt_oe), .ext_lvl(ext), .per_out(per_out), .per_oe(per_oe));
  // Clock and hang guard
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected status after levels x then y
  function logic [7:0] evx(input logic [2:0] t, input logic [7:0] x, input logic [7:0] y);
    case (t)
      3'h0: return x & ~y;
      3'h1: return ~x & y;
      3'h2: return x ^ y;
      3'h3: return ~x | ~y;
      3'h4: return x | y;
      default: return 8'h00;
    endcase
  endfunction
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] ad_, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad_;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the cycle guard ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task rdc(input string nm, input logic [11:0] ad_, input logic [31:0] e);
    apb(0, ad_, 0);
    chk(nm, e, rd);
  endtask
  task modes(input logic [7:0] d, input logic [7:0] h);
    for (int n = 0; n < 8; n++) rdc("mode", `GPC_MODE_BASE + 12'(4 * n), h[n] ? 2 : d[n]);
  endtask
  task end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("oe_rst", 0, {24'h0, pin_oe});
    apb(1, `GPC_DIR, 32'hFF);
    modes(8'hF0, 8'h00);
    apb(0, 12'hFFC, 0);
    chk("slverr", 1, {31'h0, er});
    // Commit is refused while locked
    apb(1, `GPC_COMMIT, 32'hFF);
    rdc("commit", `GPC_COMMIT, {24'h0, ~`GPC_PROT_RST});
    apb(1, `GPC_LOCK, `GPC_UNLOCK_KEY);
    rdc("lock", `GPC_LOCK, 0);
    apb(1, `GPC_COMMIT, 32'hFF);
    repeat (2) begin
      a = 8'(rnd());
      b = 8'(rnd());
      apb(1, `GPC_DIR, {24'h0, a});
      apb(1, `GPC_HWCTL, {24'h0, b});
      modes(a, b);
    end
    apb(1, `GPC_HWCTL, 0);
    apb(1, `GPC_DIR, 32'hFF);
    lv = 0;
    // Masked data writes with random pad enables
    repeat (16) begin
      a = 8'(rnd());
      b = 8'(rnd());
      re = 8'(rnd());
      apb(1, `GPC_PADEN, {24'h0, re});
      apb(1, {2'b0, a, 2'b0}, {24'h0, b});
      lv = (lv & ~a) | (b & a);
      @(negedge pclk);
      chk("pin_out", {24'h0, lv & re}, {24'h0, pin_out & re});
      chk("pin_oe", {24'h0, re}, {24'h0, pin_oe});
      @(posedge pclk);
      rdc("data", {2'b0, b, 2'b0}, {24'h0, lv & b});
    end
    // Pin 0 handed to peripheral signal 2
    apb(1, `GPC_PADEN, 32'hFF);
    apb(1, `GPC_FSEL, 32'h2);
    per_out <= 4'h4;
    per_oe <= 4'h4;
    apb(1, `GPC_HWCTL, 32'h1);
    repeat (3) @(negedge pclk);
    chk("hw_pin", 3, {30'h0, pin_oe[0], pin_out[0]});
    chk("alt_in", 4, {28'h0, alt_in});
    @(posedge pclk);
    apb(1, `GPC_HWCTL, 0);
    apb(1, `GPC_DIR, 0);
    // Every detection type with random enables
    for (int t = 0; t < 6; t++) begin
      a = 8'(rnd());
      b = 8'(rnd());
      mk = rnd();
      dm = rnd();
      ad = rnd();
      apb(1, `GPC_ITYPE, {8{1'b0, 3'(t)}});
      ext <= a;
      apb(1, `GPC_DMAEN, {24'h0, dm[7:0]});
      apb(1, `GPC_ADCEN, {24'h0, ad[7:0]});
      apb(1, `GPC_IMASK, {23'h0, mk[8:0]});
      apb(1, `GPC_ICLR, 32'h1FF);
      ext <= b;
      dacc = 0;
      aacc = 0;
      repeat (5) begin
        @(negedge pclk);
        dacc |= dma_req;
        aacc |= adc_trig;
      end
      @(posedge pclk);
      re = evx(3'(t), a, b);
      rs = {1'b1, re};
      dma_done <= 1;
      @(posedge pclk);
      dma_done <= 0;
      rdc("raw", `GPC_RAWST, {23'h0, rs});
      rdc("masked", `GPC_MSKST, {23'h0, rs & mk[8:0]});
      rdc("pins", {2'b0, a, 2'b0}, {24'h0, b & a});
      chk("irq", {31'h0, |(rs & mk[8:0])}, {31'h0, irq});
      chk("dma_req", {24'h0, re & dm[7:0]}, {24'h0, dacc});
      chk("adc", {31'h0, |(re & ad[7:0])}, {31'h0, aacc});
      c = rnd();
      apb(1, `GPC_ICLR, {23'h0, c[8:0]});
      lv = (t == 3) ? ~b : (t == 4) ? b : 8'h0;
      rdc("clr", `GPC_RAWST, {23'h0, (rs & ~c[8:0]) | {1'b0, lv}});
    end
    end_of_test();
  end
endmodule
